// ---- design/stage_fault_diag_store.sv ----
/*
  per-stage fault diagnosis store of an 18-stage low-side switch, with
  stage state machines, clear-on-read command and an APB register port.
  assumes raw comparator conditions and pins already synchronous to mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module stage_fault_diag_store #(
    parameter int SHORT_CYC  = stage_diag_pkg::SHORT_FILTER_CYC,
    parameter int OTW_CYC    = stage_diag_pkg::OTW_FILTER_CYC,
    parameter int REVCUR_CYC = stage_diag_pkg::REVCUR_FILTER_CYC
) (
    input  wire logic        mclk,        // 100 MHz clock
    input  wire logic        arst_n,      // power-on reset, async
    input  wire logic        ce,          // clock enable
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb enable
    input  wire logic        pwrite,      // apb write
    input  wire logic [7:0]  paddr,       // apb byte address
    input  wire logic [31:0] pwdata,      // apb write data
    output logic      [31:0] prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error on unmapped
    input  wire logic [17:0] stageCmd,    // host on request per stage
    input  wire logic [17:0] rawScb,      // current limit reached
    input  wire logic [17:0] rawScg,      // below ground-short threshold
    input  wire logic [17:0] rawOl,       // between the two thresholds
    input  wire logic [17:0] rawOtw,      // overtemp warning
    input  wire logic [17:0] rawOtsd,     // overtemp shutdown, with hysteresis
    input  wire logic [17:0] rawRevCur,   // reverse current
    input  wire logic        supplyBad,   // supply out of range
    input  wire logic        extReset_n,  // reset pin
    input  wire logic        output_enable_pin, // enable pin level
    output logic      [17:0] stageDrive,  // stage gate on
    output logic      [17:0] revCurrent,  // filtered reverse current
    output logic             irq          // interrupt, level
);
    localparam int N = stage_diag_pkg::STAGES;

    typedef struct packed {
        stage_diag_pkg::stage_state_t [N-1:0] st;
        logic [N-1:0][1:0]   code;
        logic [N-1:0]        otFlag;
        logic [7:0]          txData;
        logic [N-1:0]        shutoffCfg;
        logic [stage_diag_pkg::PULLDOWN_W-1:0] pulldownCfg;
        logic [N-1:0]        drive;
        logic [N-1:0]        rev;
        logic [stage_diag_pkg::IRQ_W-1:0] irqSt;
        logic [stage_diag_pkg::IRQ_W-1:0] irqEn;
        logic                irq;
        logic [31:0]         rdata;
    } store_t;

    store_t s;
    store_t next_s;

    filt_if #(.N(N)) fScb ();
    filt_if #(.N(N)) fScg ();
    filt_if #(.N(N)) fOl ();
    filt_if #(.N(N)) fOtw ();
    filt_if #(.N(N)) fRev ();

    // one filter bank per fault kind; supply, ground and open load share the short count
    fault_filter #(.N(N), .TERM(SHORT_CYC))  uScb (.mclk(mclk), .arst_n(arst_n), .ce(ce), .f(fScb.filter));
    fault_filter #(.N(N), .TERM(SHORT_CYC))  uScg (.mclk(mclk), .arst_n(arst_n), .ce(ce), .f(fScg.filter));
    fault_filter #(.N(N), .TERM(SHORT_CYC))  uOl  (.mclk(mclk), .arst_n(arst_n), .ce(ce), .f(fOl.filter));
    fault_filter #(.N(N), .TERM(OTW_CYC))    uOtw (.mclk(mclk), .arst_n(arst_n), .ce(ce), .f(fOtw.filter));
    fault_filter #(.N(N), .TERM(REVCUR_CYC)) uRev (.mclk(mclk), .arst_n(arst_n), .ce(ce), .f(fRev.filter));

    logic          wrAcc;
    logic          setup;
    logic          mapped;
    logic          rdCmd;
    logic [2:0]    rdSel;
    logic          clrAll;
    logic [N-1:0]  rdMask;
    logic [N-1:0]  clrMask;
    logic          forceOff;
    logic [N-1:0]  olAllowed;
    logic          central_overtemp_flag;
    logic          failFlag;

    // one diagnosis register image, 4 stages per byte, summary at index 5
    // stages beyond the last one read as healthy
    function automatic logic [7:0] diagReg(input logic [2:0] idx,
                                           input logic [N-1:0][1:0] codes,
                                           input logic c, input logic fl);
        logic [7:0] v;
        v = '1;
        if (idx == stage_diag_pkg::SUMMARY_IDX)
        begin
            v = '0;
            v[stage_diag_pkg::SUM_CENTRAL_OVERTEMP_FLAG_BIT] = c;
            v[stage_diag_pkg::SUM_FAIL_BIT] = fl;
        end
        else
        begin
            for (int k = 0; k < stage_diag_pkg::STAGES_PER_REG; k++)
                if (int'(idx) * stage_diag_pkg::STAGES_PER_REG + k < N)
                    v[2*k +: 2] = codes[int'(idx) * stage_diag_pkg::STAGES_PER_REG + k];
        end
        return v;
    endfunction : diagReg

    always_comb
    begin
        // every strobe is qualified by ce so a frozen cycle changes nothing
        wrAcc  = psel && penable && pwrite && ce;
        setup  = psel && !penable && ce;
        mapped = (paddr <= stage_diag_pkg::ADDR_IRQ_CLR) && (paddr[1:0] == 2'b00);
        rdSel  = pwdata[stage_diag_pkg::RDCMD_W-1:0];
        // index above the summary register is not a valid read command
        rdCmd  = wrAcc && paddr == stage_diag_pkg::ADDR_RDCMD
                 && rdSel <= stage_diag_pkg::SUMMARY_IDX;
        clrAll = !extReset_n || (wrAcc && paddr == stage_diag_pkg::ADDR_CTRL
                 && pwdata[stage_diag_pkg::CTRL_DIAG_RST]);
        forceOff = supplyBad || !extReset_n || !output_enable_pin;
        // both summary bits are active low: a 0 reports a fault somewhere
        central_overtemp_flag     = ~|s.otFlag;
        failFlag = &s.code;
        // stages below the pull-down bank have no source to switch off
        olAllowed = {s.pulldownCfg, {stage_diag_pkg::PULLDOWN_FIRST{1'b1}}};
        // the summary index selects no stage, so reading it clears nothing
        for (int i = 0; i < N; i++)
        begin
            rdMask[i]  = rdCmd && (int'(rdSel) == i / stage_diag_pkg::STAGES_PER_REG);
            clrMask[i] = clrAll || rdMask[i];
        end
    end

    // supply short only seen while driven; ground short and open load only while off
    assign fScb.cond    = rawScb & s.drive;
    assign fScg.cond    = rawScg & ~s.drive;
    assign fOl.cond     = rawOl & ~s.drive & olAllowed;
    assign fOtw.cond    = (rawOtw & s.drive) | rawOtsd;
    assign fRev.cond    = rawRevCur;
    assign fScb.restart = clrMask;
    assign fScg.restart = clrMask;
    assign fOl.restart  = clrMask;
    // the warning filter keeps counting across a clear
    assign fOtw.restart = '0;
    assign fRev.restart = '0;

    always_comb
    begin
        logic [stage_diag_pkg::IRQ_W-1:0] ev;
        ev = '0;
        next_s = s;

        // the transmit image is taken before this cycle's clear and entries
        if (rdCmd)
            next_s.txData = diagReg(rdSel, s.code, central_overtemp_flag, failFlag);

        for (int i = 0; i < N; i++)
        begin
            if (clrMask[i])
            begin
                next_s.code[i]   = stage_diag_pkg::CODE_OK;
                next_s.otFlag[i] = 1'b0;
            end
            // frozen while supply is out of range; later entries overwrite
            // earlier ones, and a new entry beats a clear in the same cycle
            if (!supplyBad)
            begin
                if (fScg.hit[i])
                begin
                    next_s.code[i]   = stage_diag_pkg::CODE_SCG;
                    next_s.otFlag[i] = 1'b0;
                end
                if (fOl.hit[i])
                begin
                    next_s.code[i]   = stage_diag_pkg::CODE_OL;
                    next_s.otFlag[i] = 1'b0;
                end
                if (fScb.hit[i])
                begin
                    next_s.code[i]   = stage_diag_pkg::CODE_SCB;
                    next_s.otFlag[i] = 1'b0;
                end
                if (fOtw.hit[i])
                begin
                    next_s.code[i]   = stage_diag_pkg::CODE_SCB;
                    next_s.otFlag[i] = 1'b1;
                end
            end
            // reverse current is a live level: it drops with the raw input
            if (fRev.hit[i])
                next_s.rev[i] = 1'b1;
            else if (!rawRevCur[i])
                next_s.rev[i] = 1'b0;

            unique case (s.st[i])
                stage_diag_pkg::ST_OFF:
                    if (stageCmd[i] && !forceOff)
                        next_s.st[i] = stage_diag_pkg::ST_ON;
                stage_diag_pkg::ST_ON:
                    if (!stageCmd[i] || forceOff)
                        next_s.st[i] = stage_diag_pkg::ST_OFF;
                    else if (fScb.hit[i] && s.shutoffCfg[i])
                        next_s.st[i] = stage_diag_pkg::ST_SCB_OFF;
                stage_diag_pkg::ST_SCB_OFF:
                    if (!stageCmd[i] || forceOff)
                        next_s.st[i] = stage_diag_pkg::ST_OFF;
                    else if (rdMask[i])
                        next_s.st[i] = stage_diag_pkg::ST_ON;
                // protect leaves only to off, so a requested stage spends one cycle off before it restarts
                stage_diag_pkg::ST_PROTECT:
                    if (!rawOtsd[i])
                        next_s.st[i] = stage_diag_pkg::ST_OFF;
            endcase
            if (rawOtsd[i])
                next_s.st[i] = stage_diag_pkg::ST_PROTECT;
            // drive follows the next state, so the gate moves at the same edge
            next_s.drive[i] = (next_s.st[i] == stage_diag_pkg::ST_ON) && !forceOff;
        end

        // a fault event is dropped with its entry while the supply is out of range
        ev[stage_diag_pkg::IRQ_FAULT]  = !supplyBad
                                         && |(fScb.hit | fScg.hit | fOl.hit | fOtw.hit);
        ev[stage_diag_pkg::IRQ_REVCUR] = |fRev.hit;
        ev[stage_diag_pkg::IRQ_TX]     = rdCmd;

        if (wrAcc)
        begin
            unique case (paddr)
                stage_diag_pkg::ADDR_SHUTOFF:  next_s.shutoffCfg  = pwdata[N-1:0];
                stage_diag_pkg::ADDR_PULLDOWN: next_s.pulldownCfg = pwdata[stage_diag_pkg::PULLDOWN_W-1:0];
                stage_diag_pkg::ADDR_IRQ_EN:   next_s.irqEn       = pwdata[stage_diag_pkg::IRQ_W-1:0];
                stage_diag_pkg::ADDR_IRQ_CLR:  next_s.irqSt       = s.irqSt & ~pwdata[stage_diag_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // sticky events are applied after the clear so a new event survives
        next_s.irqSt = next_s.irqSt | ev;
        // registered so the line never glitches on a status write
        next_s.irq   = |(next_s.irqSt & next_s.irqEn);

        // read data captured in the setup phase, so the access phase needs no wait
        if (setup)
        begin
            next_s.rdata = '0;
            unique case (paddr)
                stage_diag_pkg::ADDR_SHUTOFF:  next_s.rdata[N-1:0] = s.shutoffCfg;
                stage_diag_pkg::ADDR_PULLDOWN: next_s.rdata[stage_diag_pkg::PULLDOWN_W-1:0] = s.pulldownCfg;
                stage_diag_pkg::ADDR_TXDATA:   next_s.rdata[7:0] = s.txData;
                stage_diag_pkg::ADDR_STAGEON:  next_s.rdata[N-1:0] = s.drive;
                stage_diag_pkg::ADDR_REVCUR:   next_s.rdata[N-1:0] = s.rev;
                stage_diag_pkg::ADDR_IRQ_ST:   next_s.rdata[stage_diag_pkg::IRQ_W-1:0] = s.irqSt;
                stage_diag_pkg::ADDR_IRQ_EN:   next_s.rdata[stage_diag_pkg::IRQ_W-1:0] = s.irqEn;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s             <= '0;
            s.code        <= {N{stage_diag_pkg::CODE_OK}};
            s.txData      <= '1;
            // safest default: every stage shuts off on a supply short
            s.shutoffCfg  <= stage_diag_pkg::SHUTOFF_RST;
            s.pulldownCfg <= stage_diag_pkg::PULLDOWN_RST;
        end
        else if (ce)
            s <= next_s;
    end

    // a frozen clock enable stretches the access phase instead of losing it
    assign pready     = ce;
    // unmapped or unaligned words answer with an error; writes there are dropped
    assign pslverr    = psel && penable && !mapped;
    assign prdata     = s.rdata;
    assign stageDrive = s.drive;
    assign revCurrent = s.rev;
    assign irq        = s.irq;
endmodule : stage_fault_diag_store
`default_nettype wire

// ---- design/stage_diag_pkg.sv ----
/*
  constants, register map and types of the stage fault diagnosis store.
  assumes a 100 MHz mclk; filter counts are derived from that period.
*/
`default_nettype none
package stage_diag_pkg;
    localparam int STAGES         = 18;
    localparam int CLK_PERIOD_NS  = 10;
    // filter times in ns, each inside its allowed window
    localparam int OTW_FILTER_NS  = 20000;
    localparam int SHORT_FILTER_NS = 100000;
    localparam int REVCUR_FILTER_NS = 40000;
    localparam int OTW_FILTER_CYC = (OTW_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_FILTER_CYC = (SHORT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REVCUR_FILTER_CYC = (REVCUR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_SHUTOFF  = 8'h04;
    localparam logic [7:0] ADDR_PULLDOWN = 8'h08;
    localparam logic [7:0] ADDR_RDCMD    = 8'h0c;
    localparam logic [7:0] ADDR_TXDATA   = 8'h10;
    localparam logic [7:0] ADDR_STAGEON  = 8'h14;
    localparam logic [7:0] ADDR_REVCUR   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ST   = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h20;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h24;

    localparam int CTRL_DIAG_RST = 0;
    localparam int RDCMD_W       = 3;
    localparam logic [2:0] SUMMARY_IDX = 3'h5;
    localparam int STAGES_PER_REG = 4;
    localparam int SUM_CENTRAL_OVERTEMP_FLAG_BIT  = 0;
    localparam int SUM_FAIL_BIT  = 1;
    localparam int PULLDOWN_FIRST = 10;
    localparam int PULLDOWN_W    = 8;
    localparam logic [7:0] PULLDOWN_RST = 8'hff;
    localparam logic [17:0] SHUTOFF_RST = 18'h3ffff;

    localparam logic [1:0] CODE_OK  = 2'b11;
    localparam logic [1:0] CODE_SCB = 2'b10;
    localparam logic [1:0] CODE_OL  = 2'b01;
    localparam logic [1:0] CODE_SCG = 2'b00;

    localparam int IRQ_W      = 3;
    localparam int IRQ_FAULT  = 0;
    localparam int IRQ_REVCUR = 1;
    localparam int IRQ_TX     = 2;

    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_ON      = 2'b01,
        ST_SCB_OFF = 2'b10,
        ST_PROTECT = 2'b11
    } stage_state_t;
endpackage : stage_diag_pkg
`default_nettype wire

// ---- design/filt_if.sv ----
/*
  bundle between the store and one bank of fault filters.
  assumes both ends run on the same mclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface filt_if #(parameter int N = 18);
    logic [N-1:0] cond;
    logic [N-1:0] restart;
    logic [N-1:0] hit;
    modport filter (input cond, input restart, output hit);
    modport user   (output cond, output restart, input hit);
endinterface : filt_if
`default_nettype wire

// ---- design/fault_filter.sv ----
/*
  bank of N persistence filters; hit pulses one cycle once a condition
  has stood for TERM cycles. assumes conditions synchronous to mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module fault_filter #(
    parameter int N    = 18,
    parameter int TERM = 10000
) (
    input  wire logic mclk,    // clock
    input  wire logic arst_n,  // async reset
    input  wire logic ce,      // clock enable
    filt_if.filter    f        // conditions, restarts, hits
);
    localparam int W = $clog2(TERM + 1);
    localparam logic [W-1:0] TERM_W = W'(TERM);
    localparam logic [W-1:0] LAST_W = W'(TERM - 1);

    typedef struct packed {
        logic [N-1:0][W-1:0] cnt;
        logic [N-1:0]        hit;
    } filt_state_t;

    filt_state_t s;
    filt_state_t next_s;

    always_comb
    begin
        next_s = s;
        for (int i = 0; i < N; i++)
        begin
            next_s.hit[i] = 1'b0;
            if (f.restart[i] || !f.cond[i])
                next_s.cnt[i] = '0;
            else if (s.cnt[i] < TERM_W)
            begin
                next_s.cnt[i] = s.cnt[i] + W'(1);
                next_s.hit[i] = (s.cnt[i] == LAST_W);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign f.hit = s.hit;
endmodule : fault_filter
`default_nettype wire

// ---- dv/sfd_chk.sv ----
/*
  port assertions for the stage fault diagnosis store.
  assumes it is bound into the store and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module sfd_chk #(
    parameter int REVCUR_CYC = 12  // reverse current filter count
) (
    input  wire logic        mclk,              // clock
    input  wire logic        arst_n,            // async reset
    input  wire logic        ce,                // clock enable
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb enable
    input  wire logic [7:0]  paddr,             // apb address
    input  wire logic        pready,            // apb ready
    input  wire logic        pslverr,           // apb error
    input  wire logic [17:0] stageCmd,          // stage on request
    input  wire logic [17:0] rawOtsd,           // overtemp shutdown
    input  wire logic [17:0] rawRevCur,         // raw reverse current
    input  wire logic        supplyBad,         // supply out of range
    input  wire logic        extReset_n,        // reset pin
    input  wire logic        output_enable_pin, // enable pin
    input  wire logic [17:0] stageDrive,        // stage on
    input  wire logic [17:0] revCurrent         // filtered reverse current
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    logic        forceOff;
    logic [15:0] revRun;
    assign forceOff = supplyBad || !extReset_n || !output_enable_pin;
    // saturating run length of reverse current on stage 2, frozen with ce
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            revRun <= 16'h0;
        else if (!ce)
            revRun <= revRun;
        else if (rawRevCur[2])
            revRun <= (revRun == 16'hffff) ? revRun : revRun + 16'h1;
        else
            revRun <= 16'h0;
    end
    AST_FORCE_OFF: assert property (ce && forceOff |=> stageDrive == 18'h0)
        else $error("stage driven while forced off");
    AST_RESET_OFF: assert property ($rose(arst_n) |-> stageDrive == 18'h0 && revCurrent == 18'h0)
        else $error("stage not off after reset");
    AST_CMD_OFF: assert property (ce && !stageCmd[1] |=> !stageDrive[1])
        else $error("stage driven without request");
    AST_PROTECT: assert property (ce && rawOtsd[0] |=> !stageDrive[0])
        else $error("stage driven during shutdown");
    AST_PROTECT_EXIT: assert property (ce && $fell(rawOtsd[0]) |=> !stageDrive[0])
        else $error("protect state left straight to on");
    AST_READY: assert property (pready == ce)
        else $error("ready does not follow clock enable");
    AST_UNMAPPED: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access not refused");
    AST_REV_MIN: assert property ($rose(revCurrent[2]) |-> revRun >= REVCUR_CYC - 1)
        else $error("reverse current flagged too early");
    AST_REV_MAX: assert property (revRun == REVCUR_CYC + 3 |-> revCurrent[2])
        else $error("reverse current not flagged in time");
endmodule : sfd_chk
bind stage_fault_diag_store sfd_chk #(.REVCUR_CYC(REVCUR_CYC)) chk (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .stageCmd(stageCmd), .rawOtsd(rawOtsd), .rawRevCur(rawRevCur),
    .supplyBad(supplyBad), .extReset_n(extReset_n), .output_enable_pin(output_enable_pin),
    .stageDrive(stageDrive), .revCurrent(revCurrent)
);
`default_nettype wire

// ---- dv/apb_host.sv ----
/*
  apb host model standing in for the serial control link master.
  assumes a slave that may stretch the access phase with pready.
*/
`timescale 1ns/100ps
`default_nettype none
module apb_host (
    output logic             psel,    // select
    output logic             penable, // enable
    output logic             pwrite,  // direction
    output logic [7:0]       paddr,   // byte address
    output logic [31:0]      pwdata,  // write data
    input  wire logic        mclk,    // clock
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // ready
    input  wire logic        pslverr  // error
);
    initial
    begin
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // diagnosis is fetched only through a bus read, never peeked
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  self-checking bench of the diagnosis store: apb host and raw fault stimulus.
  assumes shortened filter counts; ce is low only in the freeze scenario.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int SC = 20;
    localparam int OC = 8;
    localparam int RC = 12;
    logic        mclk, arst_n, ce, psel, penable, pwrite, pready, pslverr, irq, supplyBad, extReset_n, oePin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [17:0] stageCmd, rawScb, rawScg, rawOl, rawOtw, rawOtsd, rawRevCur, stageDrive, revCurrent;
    int          errTotal = 0;
    int          checked = 0;
    stage_fault_diag_store #(.SHORT_CYC(SC), .OTW_CYC(OC), .REVCUR_CYC(RC)) DUT (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stageCmd(stageCmd), .rawScb(rawScb), .rawScg(rawScg), .rawOl(rawOl), .rawOtw(rawOtw),
        .rawOtsd(rawOtsd), .rawRevCur(rawRevCur), .supplyBad(supplyBad), .extReset_n(extReset_n),
        .output_enable_pin(oePin), .stageDrive(stageDrive), .revCurrent(revCurrent), .irq(irq));
    apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b0, a, 32'h0, q, e);
        cmp(q, x);
    endtask : rdchk
    task automatic drv(input logic [31:0] x);
        rdchk(stage_diag_pkg::ADDR_STAGEON, x);
    endtask : drv
    task automatic diag(input logic [2:0] i, input logic [31:0] x);
        wr(stage_diag_pkg::ADDR_RDCMD, {29'h0, i});
        rdchk(stage_diag_pkg::ADDR_TXDATA, x);
    endtask : diag
    task automatic printVerdict();
        $display("mismatches %0d comparisons %0d", errTotal, checked);
        if (errTotal == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : printVerdict
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #200000;
        errTotal++;
        printVerdict();
    end
    initial
    begin
        logic [31:0] q;
        logic        e;
        {ce, extReset_n, oePin, arst_n, supplyBad} = 5'b11100;
        {stageCmd, rawScb, rawScg, rawOl, rawOtw, rawOtsd, rawRevCur} = '0;
        cyc(10);
        arst_n <= 1'b1;
        wr(stage_diag_pkg::ADDR_IRQ_EN, 32'h1);
        drv(32'h0);
        diag(3'h0, 32'hff);
        diag(3'h5, 32'h3);
        rawScg[3] <= 1'b1;
        cyc(SC + 3);
        rawScg[3] <= 1'b0;
        cmp({31'h0, irq}, 32'h1);
        diag(3'h5, 32'h1);
        diag(3'h0, 32'h3f);
        diag(3'h0, 32'hff);
        wr(stage_diag_pkg::ADDR_IRQ_CLR, 32'h7);
        wr(stage_diag_pkg::ADDR_IRQ_EN, 32'h0);
        cmp({31'h0, irq}, 32'h0);
        // two runs just short of the filter, split by one quiet cycle
        rawOl[4] <= 1'b1;
        cyc(SC - 2);
        rawOl[4] <= 1'b0;
        cyc(1);
        rawOl[4] <= 1'b1;
        cyc(SC - 2);
        rawOl[4] <= 1'b0;
        diag(3'h1, 32'hff);
        rawOl[4] <= 1'b1;
        cyc(SC + 3);
        rawOl[4] <= 1'b0;
        rawScg[4] <= 1'b1;
        cyc(SC + 3);
        rawScg[4] <= 1'b0;
        cmp({31'h0, irq}, 32'h0);
        diag(3'h1, 32'hfc);
        wr(stage_diag_pkg::ADDR_PULLDOWN, 32'hfe);
        rawOl[10] <= 1'b1;
        cyc(SC + 3);
        rawOl[10] <= 1'b0;
        diag(3'h2, 32'hff);
        rawScg[10] <= 1'b1;
        cyc(SC + 3);
        rawScg[10] <= 1'b0;
        diag(3'h2, 32'hcf);
        stageCmd[0] <= 1'b1;
        cyc(3);
        drv(32'h1);
        rawOtsd[0] <= 1'b1;
        cyc(OC + 3);
        drv(32'h0);
        diag(3'h5, 32'h0);
        rawOtsd[0] <= 1'b0;
        diag(3'h0, 32'hfe);
        cyc(3);
        drv(32'h1);
        stageCmd[1] <= 1'b1;
        rawScb[1] <= 1'b1;
        cyc(SC + 6);
        drv(32'h1);
        diag(3'h0, 32'hfb);
        drv(32'h3);
        cyc(SC + 6);
        drv(32'h1);
        rawScb[1] <= 1'b0;
        diag(3'h0, 32'hfb);
        wr(stage_diag_pkg::ADDR_SHUTOFF, 32'h3fffd);
        rawScb[1] <= 1'b1;
        cyc(SC + 6);
        drv(32'h3);
        diag(3'h0, 32'hfb);
        rawScb[1] <= 1'b0;
        oePin <= 1'b0;
        cyc(2);
        drv(32'h0);
        {oePin, supplyBad} <= 2'b11;
        rawScg[5] <= 1'b1;
        cyc(SC + 6);
        drv(32'h0);
        {rawScg[5], supplyBad} <= 2'b00;
        diag(3'h1, 32'hff);
        rawScg[7] <= 1'b1;
        cyc(SC + 3);
        {rawScg[7], extReset_n} <= 2'b00;
        cyc(2);
        extReset_n <= 1'b1;
        diag(3'h1, 32'hff);
        rawScg[8] <= 1'b1;
        cyc(SC + 3);
        rawScg[8] <= 1'b0;
        cyc(1);
        rawScg[6] <= 1'b1;
        cyc(SC - 6);
        wr(stage_diag_pkg::ADDR_CTRL, 32'h1);
        cyc(SC - 6);
        rawScg[6] <= 1'b0;
        diag(3'h1, 32'hff);
        diag(3'h2, 32'hff);
        ce <= 1'b0;
        rawScg[9] <= 1'b1;
        cyc(SC + 3);
        {ce, rawScg[9]} <= 2'b10;
        diag(3'h2, 32'hff);
        rawOtw[0] <= 1'b1;
        cyc(OC + 3);
        rawOtw[0] <= 1'b0;
        drv(32'h3);
        diag(3'h0, 32'hfe);
        rawRevCur[2] <= 1'b1;
        cyc(RC - 3);
        rawRevCur[2] <= 1'b0;
        rdchk(stage_diag_pkg::ADDR_REVCUR, 32'h0);
        rawRevCur[2] <= 1'b1;
        cyc(RC + 3);
        rdchk(stage_diag_pkg::ADDR_REVCUR, 32'h4);
        rawRevCur[2] <= 1'b0;
        host.xfer(1'b0, 8'h40, 32'h0, q, e);
        cmp(q, 32'h0);
        cmp({31'h0, e}, 32'h1);
        printVerdict();
    end
endmodule : tb_top
`default_nettype wire
